// File: operand_format_pkg.sv
package operand_format_pkg;

    // ==========================================================
    // Widths and counts
    // ==========================================================
    localparam int EXT_WIDTH  = 80;
    localparam int WORD_WIDTH = 16;
    localparam int ADDR_WIDTH = 20;
    localparam int NUM_REGS   = 8;
    localparam int BCD_DIGITS = 18;
    localparam int BIN_BITS   = 64;

    // ==========================================================
    // Encoding constants
    // ==========================================================
    localparam logic [4:0]            ESCAPE_CLASS_TAG = 5'h1b;
    localparam logic [ADDR_WIDTH-1:0] ADDR_STEP        = 20'h0_0002;
    localparam logic [14:0]           EXT_BIAS         = 15'h3fff;
    localparam logic [14:0]           SHORT_BIAS       = 15'h007f;
    localparam logic [14:0]           LONG_BIAS        = 15'h03ff;
    localparam logic [14:0]           EXT_EXP_MAX      = 15'h7fff;
    localparam logic [14:0]           SHORT_FRAC_SCALE = 15'h0095;
    localparam logic [14:0]           LONG_FRAC_SCALE  = 15'h0432;
    localparam logic [15:0]           SHORT_EXP_MAX    = 16'h00ff;
    localparam logic [15:0]           LONG_EXP_MAX     = 16'h07ff;
    localparam logic [15:0]           INT_POINT        = 16'h403e;
    localparam logic [63:0]           INT_INDEFINITE   = 64'h8000_0000_0000_0000;
    localparam logic [63:0]           BCD_MAX          = 64'h0de0_b6b3_a763_ffff;
    localparam logic [79:0]           BCD_INDEFINITE   = 80'hffff_0000_0000_0000_0000;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        FMT_WORD_INT, FMT_SHORT_INT, FMT_LONG_INT, FMT_PACKED_DEC,
        FMT_SHORT_REAL, FMT_LONG_REAL, FMT_EXT_REAL
    } fmt_e;

    typedef enum logic [1:0] {RND_NEAREST, RND_DOWN, RND_UP, RND_ZERO} round_e;

    typedef struct packed {
        logic [15:0]           opcode;
        logic                  store;
        fmt_e                  fmt;
        logic                  stack_mode;
        logic                  pop;
        logic [2:0]            reg_index;
        logic [ADDR_WIDTH-1:0] base_addr;
    } cmd_s;

    typedef struct packed {
        logic                  req;
        logic                  we;
        logic [ADDR_WIDTH-1:0] addr;
        logic [WORD_WIDTH-1:0] wdata;
    } mem_req_s;

    // Memory footprint of each format in 16-bit words, minus one
    function automatic logic [2:0] last_word(input fmt_e f);
        case (f)
            FMT_WORD_INT:                 last_word = 3'h0;
            FMT_SHORT_INT, FMT_SHORT_REAL: last_word = 3'h1;
            FMT_LONG_INT, FMT_LONG_REAL:   last_word = 3'h3;
            default:                      last_word = 3'h4;
        endcase
    endfunction

endpackage

// File: numeric_register_file.sv
`timescale 1ns/1ps
// ==========================================================
// Eight-entry register storage, registered read data
// ==========================================================
module numeric_register_file #(
    parameter int WIDTH = 80,
    parameter int DEPTH = 8
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_write,
    input  wire logic [$clog2(DEPTH)-1:0] i_write_index,
    input  wire logic [WIDTH-1:0]         i_write_data,
    input  wire logic [$clog2(DEPTH)-1:0] i_read_index,
    output logic      [WIDTH-1:0]         o_read_data
);
    logic [WIDTH-1:0] storage [DEPTH];

    // No reset on the array: contents are undefined until loaded
    always_ff @(posedge i_clock) begin
        if (i_write) begin
            storage[i_write_index] <= i_write_data;
        end
    end

    // Read data out of a flop, one cycle after the index
    always_ff @(posedge i_clock) begin
        o_read_data <= storage[i_read_index];
    end
endmodule // numeric_register_file

// File: numeric_operand_format_unit.sv
// Summary of operation
// [RULE1] Eight 80-bit registers, addressed by fixed index or relative to a stack top.
// [RULE2] Every register value is held in the one 80-bit extended-real layout.
// [RULE3] Loads convert 16/32/64-bit integers, 32/64/80-bit reals and 18-digit decimal.
// [RULE4] Stores convert a register value into the format that the command selects.
// [RULE5] Memory operands run least significant word first at rising addresses.
// [RULE6] Only the first address is given; later words follow from the format width.
// [RULE7] Operands should start at even addresses for speed; odd ones still work.
// [RULE8] Integer formats are 16, 32 and 64 bits plus an 80-bit 18-digit decimal.
// [RULE9] Real formats are 32, 64 and 80 bits, the last equal to the register layout.
// [RULE10] Only escape-class opcodes passed on by the host are executed.
// [RULE11] Narrowing conversions round to nearest even unless another mode is chosen.
`timescale 1ns/1ps
module numeric_operand_format_unit (
    input  wire logic                                       i_clock,
    input  wire logic                                       i_reset_n,
    input  wire logic                                       i_cmd_valid,
    input  wire operand_format_pkg::cmd_s                   i_cmd,
    input  wire operand_format_pkg::round_e                 i_round_mode,
    output logic                                            o_cmd_ready,
    output operand_format_pkg::mem_req_s                    o_mem,
    input  wire logic                                       i_mem_ack,
    input  wire logic [operand_format_pkg::WORD_WIDTH-1:0]  i_mem_rdata,
    output logic                                            o_done,
    output logic                                            o_error,
    output logic      [2:0]                                 o_top
);
    import operand_format_pkg::*;

    typedef enum {IDLE, FETCH, DECIMAL, NORMALIZE, CONVERT, DABBLE, STORE} state_e;

    state_e                 state;
    cmd_s                   cmd;
    logic [2:0]             word;
    logic [6:0]             count;
    logic [EXT_WIDTH-1:0]   buffer;
    logic [BIN_BITS-1:0]    bin;
    logic [71:0]            bcd;
    logic                   conv_err;
    logic [EXT_WIDTH-1:0]   load_ext;
    logic [EXT_WIDTH-1:0]   read_data;
    logic [EXT_WIDTH-1:0]   store_image;
    logic                   store_err;
    logic [BIN_BITS-1:0]    int_mag;
    logic [2:0]             read_index;
    logic                   accept;
    logic                   escape_ok;

    // ==========================================================
    // Helper functions
    // ==========================================================
    // Rounding increment decision for every mode
    function automatic logic round_up(input logic s, input logic lsb, input logic g,
                                      input logic st, input round_e rm);
        case (rm)
            RND_NEAREST: round_up = g & (st | lsb); // RULE11
            RND_UP:      round_up = ~s & (g | st);
            RND_DOWN:    round_up = s & (g | st);
            default:     round_up = 1'b0;
        endcase
    endfunction

    // Left-justify a magnitude; offset is the biased weight of bit 0 plus 63
    function automatic logic [79:0] normalize(input logic neg, input logic [63:0] mag,
                                              input logic [14:0] offset);
        logic [5:0] lz;
        begin
            lz = 6'h00;
            for (int i = 0; i < 64; i++) begin
                if (mag[i]) lz = 6'(63 - i);
            end
            if (mag == 64'h0000_0000_0000_0000) normalize = {neg, 79'h0};
            else normalize = {neg, 15'(offset - 15'(lz)), mag << lz}; // RULE2
        end
    endfunction

    // Narrow an extended value to a short or long real: {overflow, image}
    function automatic logic [64:0] pack_real(input logic s, input logic [14:0] e,
                                              input logic [63:0] m, input logic is_long,
                                              input round_e rm);
        logic [53:0] mant;
        logic [15:0] ne;
        logic [15:0] emax;
        logic [14:0] ebias;
        logic [51:0] frac;
        logic        g;
        logic        st;
        logic        over;
        begin
            ebias = is_long ? LONG_BIAS : SHORT_BIAS;
            emax  = is_long ? LONG_EXP_MAX : SHORT_EXP_MAX;
            mant  = is_long ? {1'b0, m[63:11]} : {30'h0, m[63:40]};
            g     = is_long ? m[10] : m[39];
            st    = is_long ? |m[9:0] : |m[38:0];
            mant  = mant + 54'(round_up(s, mant[0], g, st, rm)); // RULE11
            ne    = {1'b0, e} + {1'b0, ebias} - {1'b0, EXT_BIAS}
                    + 16'(is_long ? mant[53] : mant[24]);
            frac  = is_long ? mant[51:0] : {29'h0, mant[22:0]};
            over  = 1'b0;
            if (e == EXT_EXP_MAX) begin
                // Infinity keeps a zero fraction, a NaN stays a NaN
                ne   = emax;
                frac = is_long ? m[62:11] : {29'h0, m[62:40]};
                frac[is_long ? 51 : 22] = |m[62:0];
            end else if ({1'b0, e} + {1'b0, ebias} <= {1'b0, EXT_BIAS}) begin
                // Too small for a normal result: flushed to signed zero
                ne   = 16'h0000;
                frac = 52'h0;
            end else if (ne >= emax) begin
                ne   = emax;
                frac = 52'h0;
                over = 1'b1;
            end
            pack_real = is_long ? {over, s, ne[10:0], frac}
                                : {over, 32'h0, s, ne[7:0], frac[22:0]};
        end
    endfunction

    // One double-dabble step: adjust digits, then shift in one bit
    function automatic logic [71:0] dabble(input logic [71:0] d, input logic b);
        logic [71:0] t;
        begin
            t = d;
            for (int i = 0; i < BCD_DIGITS; i++) begin
                if (t[4*i +: 4] > 4'h4) t[4*i +: 4] = t[4*i +: 4] + 4'h3;
            end
            dabble = {t[70:0], b};
        end
    endfunction

    // ==========================================================
    // Register file and addressing
    // ==========================================================
    assign accept    = i_cmd_valid & o_cmd_ready;
    assign escape_ok = (i_cmd.opcode[15:11] == ESCAPE_CLASS_TAG); // RULE10
    // Stack mode reads relative to the top, fixed mode by index
    assign read_index = i_cmd.stack_mode ? 3'(o_top + i_cmd.reg_index) : i_cmd.reg_index; // RULE1

    numeric_register_file #(
        .WIDTH(EXT_WIDTH),
        .DEPTH(NUM_REGS)
    ) u_regs (
        .i_clock      (i_clock),
        .i_write      (state == NORMALIZE),
        .i_write_index(cmd.stack_mode ? 3'(o_top - 3'h1) : cmd.reg_index), // RULE1
        .i_write_data (load_ext),
        .i_read_index (read_index),
        .o_read_data  (read_data)
    );

    // Stack top moves down on a push, up on a store with pop
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_top <= 3'h0;
        end else if (state == NORMALIZE && cmd.stack_mode) begin
            o_top <= o_top - 3'h1; // RULE1
        end else if (state == STORE && i_mem_ack && word == last_word(cmd.fmt)
                     && cmd.stack_mode && cmd.pop) begin
            o_top <= o_top + 3'h1;
        end
    end

    // ==========================================================
    // Load conversion into the extended layout
    // ==========================================================
    always_comb begin
        logic [63:0] raw;
        logic        neg;
        raw      = 64'h0000_0000_0000_0000;
        neg      = 1'b0;
        load_ext = {EXT_WIDTH{1'b0}};
        case (cmd.fmt) // RULE3 RULE8 RULE9
            FMT_WORD_INT:  raw = {{48{buffer[15]}}, buffer[15:0]};
            FMT_SHORT_INT: raw = {{32{buffer[31]}}, buffer[31:0]};
            FMT_LONG_INT:  raw = buffer[63:0];
            default:       raw = 64'h0000_0000_0000_0000;
        endcase
        neg = raw[63];
        case (cmd.fmt)
            FMT_WORD_INT, FMT_SHORT_INT, FMT_LONG_INT:
                load_ext = normalize(neg, neg ? -raw : raw, 15'(INT_POINT));
            FMT_PACKED_DEC:
                load_ext = normalize(buffer[79], bin, 15'(INT_POINT));
            FMT_SHORT_REAL:
                if (buffer[30:23] == 8'h00)
                    load_ext = normalize(buffer[31], {41'h0, buffer[22:0]},
                                         15'(INT_POINT) - SHORT_FRAC_SCALE);
                else
                    load_ext = {buffer[31], buffer[30:23] == 8'hff ? EXT_EXP_MAX :
                                15'(buffer[30:23]) + EXT_BIAS - SHORT_BIAS,
                                1'b1, buffer[22:0], 40'h0};
            FMT_LONG_REAL:
                if (buffer[62:52] == 11'h000)
                    load_ext = normalize(buffer[63], {12'h0, buffer[51:0]},
                                         15'(INT_POINT) - LONG_FRAC_SCALE);
                else
                    load_ext = {buffer[63], buffer[62:52] == 11'h7ff ? EXT_EXP_MAX :
                                15'(buffer[62:52]) + EXT_BIAS - LONG_BIAS,
                                1'b1, buffer[51:0], 11'h0};
            default: load_ext = buffer; // Extended passes unchanged
        endcase
    end

    // ==========================================================
    // Store conversion out of the extended layout
    // ==========================================================
    always_comb begin
        logic        s;
        logic [14:0] e;
        logic [63:0] m;
        logic [15:0] rs;
        logic [127:0] wide;
        logic        big;
        logic        st;
        logic [64:0] mag;
        logic [64:0] limit;
        logic [63:0] signed_val;
        logic [64:0] real_img;
        limit      = '0;
        s          = read_data[79];
        e          = read_data[78:64];
        m          = read_data[63:0];
        rs         = INT_POINT - {1'b0, e};
        big        = {1'b0, e} > INT_POINT;
        wide       = (rs > 16'h007f) ? 128'h0 : ({m, 64'h0} >> rs[6:0]);
        st         = |wide[62:0] | ((rs > 16'h007f) & |m);
        mag        = {1'b0, wide[127:64]} + 65'(round_up(s, wide[64], wide[63], st,
                                                         i_round_mode)); // RULE11
        case (cmd.fmt)
            FMT_WORD_INT:  limit = {1'b0, INT_INDEFINITE >> 48};
            FMT_SHORT_INT: limit = {1'b0, INT_INDEFINITE >> 32};
            FMT_LONG_INT:  limit = {1'b0, INT_INDEFINITE};
            default:       limit = {1'b0, BCD_MAX} + 65'h1;
        endcase
        // Negative range reaches one further than positive, except in decimal
        store_err  = big | ((s && cmd.fmt != FMT_PACKED_DEC) ? mag > limit : mag >= limit);
        signed_val = s ? -mag[63:0] : mag[63:0];
        int_mag    = mag[63:0];
        real_img   = pack_real(s, e, m, cmd.fmt == FMT_LONG_REAL, i_round_mode);
        store_image = {EXT_WIDTH{1'b0}};
        case (cmd.fmt) // RULE4
            FMT_WORD_INT:  store_image[15:0] = store_err ? INT_INDEFINITE[63:48]
                                                         : signed_val[15:0];
            FMT_SHORT_INT: store_image[31:0] = store_err ? INT_INDEFINITE[63:32]
                                                         : signed_val[31:0];
            FMT_LONG_INT:  store_image[63:0] = store_err ? INT_INDEFINITE : signed_val;
            FMT_PACKED_DEC: store_image = BCD_INDEFINITE;
            FMT_SHORT_REAL, FMT_LONG_REAL: begin
                store_image[63:0] = real_img[63:0];
                store_err = real_img[64];
            end
            default: begin
                store_image = read_data;
                store_err = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Command sequencing and memory word transfers
    // ==========================================================
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            state       <= IDLE;
            cmd         <= '0;
            word        <= 3'h0;
            count       <= 7'h00;
            buffer      <= '0;
            bin         <= '0;
            bcd         <= '0;
            conv_err    <= 1'b0;
            o_cmd_ready <= 1'b1;
            o_mem       <= '0;
            o_done      <= 1'b0;
            o_error     <= 1'b0;
        end else begin
            o_done  <= 1'b0;
            o_error <= 1'b0;
            case (state)
                IDLE: if (accept) begin
                    cmd  <= i_cmd;
                    word <= 3'h0;
                    if (!escape_ok) begin
                        o_done  <= 1'b1; // RULE10
                        o_error <= 1'b1;
                    end else if (i_cmd.store) begin
                        o_cmd_ready <= 1'b0;
                        state       <= CONVERT;
                    end else begin
                        o_cmd_ready <= 1'b0;
                        o_mem       <= '{req: 1'b1, we: 1'b0, addr: i_cmd.base_addr,
                                         wdata: 16'h0000}; // RULE6
                        state       <= FETCH;
                    end
                end
                FETCH: if (i_mem_ack) begin
                    buffer[{word, 4'h0} +: WORD_WIDTH] <= i_mem_rdata; // RULE5
                    if (word == last_word(cmd.fmt)) begin
                        o_mem.req <= 1'b0;
                        bin       <= '0;
                        count     <= 7'h00;
                        state     <= (cmd.fmt == FMT_PACKED_DEC) ? DECIMAL : NORMALIZE;
                    end else begin
                        word       <= word + 3'h1;
                        o_mem.addr <= o_mem.addr + ADDR_STEP; // RULE6
                    end
                end
                DECIMAL: begin
                    // Most significant digit first: acc = acc * 10 + digit
                    bin   <= (bin << 3) + (bin << 1)
                             + 64'(buffer[7'(68 - 4 * int'(count)) +: 4]); // RULE3
                    count <= count + 7'h01;
                    if (count == 7'(BCD_DIGITS - 1)) state <= NORMALIZE;
                end
                NORMALIZE: begin
                    o_done      <= 1'b1;
                    o_cmd_ready <= 1'b1;
                    state       <= IDLE;
                end
                CONVERT: begin
                    buffer   <= store_image;
                    conv_err <= store_err;
                    if (cmd.fmt == FMT_PACKED_DEC && !store_err) begin
                        bin   <= int_mag;
                        buffer <= {read_data[79], 79'h0};
                        bcd   <= '0;
                        count <= 7'h00;
                        state <= DABBLE;
                    end else begin
                        o_mem <= '{req: 1'b1, we: 1'b1, addr: cmd.base_addr,
                                   wdata: store_image[15:0]}; // RULE5
                        state <= STORE;
                    end
                end
                DABBLE: begin
                    // One bit per cycle keeps the digit adders small
                    bcd   <= dabble(bcd, bin[63]); // RULE4
                    bin   <= bin << 1;
                    count <= count + 7'h01;
                    if (count == 7'(BIN_BITS - 1)) begin
                        buffer <= {buffer[79], 7'h00, dabble(bcd, bin[63])};
                        o_mem  <= '{req: 1'b1, we: 1'b1, addr: cmd.base_addr,
                                    wdata: 16'(dabble(bcd, bin[63]))};
                        state  <= STORE;
                    end
                end
                STORE: if (i_mem_ack) begin
                    if (word == last_word(cmd.fmt)) begin
                        o_mem       <= '0;
                        o_done      <= 1'b1;
                        o_error     <= conv_err;
                        o_cmd_ready <= 1'b1;
                        state       <= IDLE;
                    end else begin
                        word        <= word + 3'h1;
                        o_mem.addr  <= o_mem.addr + ADDR_STEP; // RULE6
                        o_mem.wdata <= buffer[{3'(word + 3'h1), 4'h0} +: WORD_WIDTH];
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end
endmodule // numeric_operand_format_unit

// File: numeric_format_checker.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker
// ==========================================================
module numeric_format_checker
    import operand_format_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    input  wire logic        i_cmd_valid,
    input  wire cmd_s        i_cmd,
    input  wire round_e      i_round_mode,
    input  wire logic        o_cmd_ready,
    input  wire mem_req_s    o_mem,
    input  wire logic        i_mem_ack,
    input  wire logic [15:0] i_mem_rdata,
    input  wire logic        o_done,
    input  wire logic        o_error,
    input  wire logic [2:0]  o_top
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    logic take;
    logic escape_opcode_class;
    cmd_s held;
    assign take = i_cmd_valid && o_cmd_ready;
    assign escape_opcode_class  = i_cmd.opcode[15:11] == ESCAPE_CLASS_TAG;
    // Command kept from acceptance, so later traffic can be judged
    always_ff @(posedge i_clock) if (take) held <= i_cmd;
    refuse_done_a: assert property (take && !escape_opcode_class |=> o_done && o_error)
        else $error("foreign opcode not refused");
    refuse_quiet_a: assert property (take && !escape_opcode_class |=> !o_mem.req && o_cmd_ready)
        else $error("foreign opcode caused traffic");
    busy_flag_a: assert property (take && escape_opcode_class |=> !o_cmd_ready)
        else $error("ready during command");
    error_done_a: assert property (o_error |-> o_done)
        else $error("error without done");
    first_addr_a: assert property ($rose(o_mem.req) |-> o_mem.addr == held.base_addr)
        else $error("first word not at base");
    addr_step_a: assert property (o_mem.req && i_mem_ack |=>
        !o_mem.req || o_mem.addr == $past(o_mem.addr) + ADDR_STEP) else $error("bad word step");
    req_hold_a: assert property (o_mem.req && !i_mem_ack |=>
        o_mem.req && $stable(o_mem.addr) && $stable(o_mem.wdata)) else $error("request moved");
    dir_match_a: assert property (o_mem.req |-> o_mem.we == held.store)
        else $error("transfer direction wrong");
    top_move_a: assert property (o_top != $past(o_top) |-> o_done)
        else $error("top moved outside done");
endmodule // numeric_format_checker
bind numeric_operand_format_unit numeric_format_checker numeric_format_checker_inst (.*);

// File: host_memory_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host memory behind the data channel
// ==========================================================
module host_memory_model
    import operand_format_pkg::*;
(
    input  wire logic        i_clock,
    input  wire mem_req_s    i_mem,
    input  wire logic        i_slow,
    output logic             o_mem_ack,
    output logic [15:0]      o_mem_rdata
);
    logic [15:0] mem [0:255];
    logic [1:0]  wait_cnt;
    initial {o_mem_ack, o_mem_rdata, wait_cnt} = '0;
    // One ack per word; idle read data churns so a stale sample shows up
    always @(posedge i_clock) begin
        o_mem_ack <= 1'b0;
        o_mem_rdata <= ~o_mem_rdata;
        if (i_mem.req && !o_mem_ack) begin
            wait_cnt <= wait_cnt + 2'h1;
            if (!i_slow || wait_cnt == 2'h3) begin
                o_mem_ack <= 1'b1;
                wait_cnt <= 2'h0;
                if (i_mem.we) mem[i_mem.addr[8:1]] <= i_mem.wdata;
                else o_mem_rdata <= mem[i_mem.addr[8:1]];
            end
        end
    end
endmodule // host_memory_model

// File: numeric_operand_format_unit_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module numeric_operand_format_unit_tb;
    import operand_format_pkg::*;
    localparam logic [15:0] OP_NUM = 16'hd9c0; // Carries the escape class tag
    logic        i_clock, i_reset_n, i_cmd_valid, o_cmd_ready, i_mem_ack, o_done, o_error, slow;
    cmd_s        i_cmd;
    round_e      i_round_mode;
    mem_req_s    o_mem;
    logic [15:0] i_mem_rdata;
    logic [2:0]  o_top;
    int          fails = 0, check_count = 0, cycles = 0;
    numeric_operand_format_unit numeric_operand_format_unit_inst (.*);
    host_memory_model host_memory_model_inst (.i_clock(i_clock), .i_mem(o_mem), .i_slow(slow),
        .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));
    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [15:0] m(input int a);
        return host_memory_model_inst.mem[a];
    endfunction
    // One command, then a bounded wait for its done pulse
    task automatic run(input logic [15:0] op, input logic st, input fmt_e f, input logic stk,
                       input logic [2:0] idx, input logic [19:0] base, input logic err);
        int n = 0;
        i_cmd = '{op, st, f, stk, stk & st, idx, base};
        i_cmd_valid = 1'b1;
        @(negedge i_clock);
        i_cmd_valid = 1'b0;
        while (o_done !== 1'b1 && n < 400) begin
            @(negedge i_clock);
            n++;
        end
        `CHK({o_done, o_error}, {1'b1, err})
    endtask
    task automatic end_sim;
        if (fails == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_refuse;
        run(16'h1234, 1'b0, FMT_WORD_INT, 1'b1, 3'h0, 20'h0_0000, 1'b1);
        `CHK(o_top, 3'h0)
    endtask
    // Word in; out as word, decimal and register image
    task automatic t_word;
        logic [15:0] img [5] = '{16'h0000, 16'h0000, 16'h0000, 16'ha000, 16'h4001};
        host_memory_model_inst.mem[0] = 16'h0005;
        run(OP_NUM, 1'b0, FMT_WORD_INT, 1'b0, 3'h2, 20'h0_0000, 1'b0);
        run(OP_NUM, 1'b1, FMT_WORD_INT, 1'b0, 3'h2, 20'h0_0020, 1'b0);
        `CHK(m(16), 16'h0005)
        run(OP_NUM, 1'b1, FMT_EXT_REAL, 1'b0, 3'h2, 20'h0_0040, 1'b0);
        for (int k = 0; k < 5; k++) `CHK(m(32 + k), img[k])
        run(OP_NUM, 1'b1, FMT_PACKED_DEC, 1'b0, 3'h2, 20'h0_0100, 1'b0);
        `CHK(m(128), 16'h0005)
    endtask
    // Odd base, slow host
    task automatic t_odd_slow;
        slow = 1'b1;
        host_memory_model_inst.mem[48] = 16'h0000;
        host_memory_model_inst.mem[49] = 16'h3f80;
        run(OP_NUM, 1'b0, FMT_SHORT_REAL, 1'b0, 3'h3, 20'h0_0061, 1'b0);
        run(OP_NUM, 1'b1, FMT_LONG_INT, 1'b0, 3'h3, 20'h0_0081, 1'b0);
        for (int k = 0; k < 4; k++) `CHK(m(64 + k), (k == 0) ? 16'h0001 : 16'h0000)
        slow = 1'b0;
    endtask
    // 2.5 to word under each rounding mode
    task automatic t_round;
        logic [15:0] exp_r [4] = '{16'h0002, 16'h0002, 16'h0003, 16'h0002};
        host_memory_model_inst.mem[80] = 16'h0000;
        host_memory_model_inst.mem[81] = 16'h4020;
        run(OP_NUM, 1'b0, FMT_SHORT_REAL, 1'b0, 3'h4, 20'h0_00a0, 1'b0);
        for (int r = 0; r < 4; r++) begin
            i_round_mode = round_e'(r);
            run(OP_NUM, 1'b1, FMT_WORD_INT, 1'b0, 3'h4, 20'h0_00c0, 1'b0);
            `CHK(m(96), exp_r[r])
        end
    endtask
    task automatic t_stack;
        run(OP_NUM, 1'b0, FMT_WORD_INT, 1'b1, 3'h0, 20'h0_0000, 1'b0);
        `CHK(o_top, 3'h7)
        run(OP_NUM, 1'b1, FMT_WORD_INT, 1'b1, 3'h0, 20'h0_00e0, 1'b0);
        `CHK({o_top, m(112)}, {3'h0, 16'h0005})
    endtask
    // Clock, and a cycle ceiling well above the run
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        {i_reset_n, i_cmd_valid, slow} = '0;
        i_cmd = '0;
        i_round_mode = RND_NEAREST;
        repeat (2) @(negedge i_clock);
        i_reset_n = 1'b1;
        t_refuse();
        t_word();
        t_odd_slow();
        t_round();
        t_stack();
        end_sim();
    end
endmodule // numeric_operand_format_unit_tb
